// ### touch_key_pkg.sv
package touch_key_pkg;
    // Timing
    localparam int CLK_NS = 40;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [11:0] HOLD_0_MS = 12'h118;
    localparam logic [11:0] HOLD_1_MS = 12'h230;
    localparam logic [11:0] HOLD_2_MS = 12'h460;
    localparam logic [11:0] HOLD_3_MS = 12'h8c0;
    // Register indices, byte address is four times the index
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_STATUS = 8'h02;
    localparam logic [7:0] IDX_SELECT = 8'h60;
    localparam logic [7:0] IDX_CONFIG = 8'h61;
    localparam logic [7:0] IDX_GAIN = 8'h80;
    localparam logic [7:0] IDX_CAL1 = 8'hb1;
    localparam logic [7:0] IDX_CAL2 = 8'hb2;
    localparam logic [7:0] IDX_CAL3 = 8'hb3;
    localparam logic [7:0] IDX_CAL_LOW = 8'hb9;
    localparam logic [7:0] IDX_PRODUCT = 8'hfd;
    localparam logic [7:0] IDX_VENDOR = 8'hfe;
    localparam logic [7:0] IDX_REVISION = 8'hff;
    // Field positions
    localparam int SEL_W = 3;
    localparam int CFG_STBY_EN_BIT = 6;
    localparam int CFG_STBY_TIME_LSB = 4;
    localparam int CFG_ACT_EN_BIT = 2;
    localparam int CFG_ACT_TIME_LSB = 0;
    localparam int STATUS_KEY_BIT = 4;
    localparam int GAIN_W = 6;
    // Reset values
    localparam logic [7:0] SELECT_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h22;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [9:0] CAL_RST = 10'h000;
    // Calibration failure codes
    localparam logic [9:0] CAL_MIN = 10'h000;
    localparam logic [9:0] CAL_MAX = 10'h3ff;
    // Inputs
    localparam int NUM_INPUTS = 3;

    typedef struct packed {
        logic [2:0] valid;
        logic [2:0][9:0] value;
    } cal_in_s;

    typedef enum logic [1:0] {HOLD_IDLE, HOLD_COUNT, HOLD_DONE} hold_state_e;
endpackage

// ### hold_timer.sv
`timescale 1ns/10ps
module hold_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic arm,
    input wire logic [11:0] limit_ms,
    output logic [11:0] elapsed_ms,
    output logic fire
);
    touch_key_pkg::hold_state_e state_reg;
    logic [11:0] elapsed_next;
    logic reach;

    assign elapsed_next = elapsed_ms + 12'h001;
    assign reach = (state_reg == touch_key_pkg::HOLD_COUNT) && tick && (elapsed_next >= limit_ms);

    // Any release drops back to idle, so a new hold starts from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= touch_key_pkg::HOLD_IDLE;
            elapsed_ms <= 12'h000;
        end else if (!arm) begin
            state_reg <= touch_key_pkg::HOLD_IDLE;
            elapsed_ms <= 12'h000;
        end else begin
            case (state_reg)
                touch_key_pkg::HOLD_IDLE: begin
                    state_reg <= touch_key_pkg::HOLD_COUNT;
                    elapsed_ms <= 12'h000;
                end
                touch_key_pkg::HOLD_COUNT: begin
                    if (tick) begin
                        elapsed_ms <= elapsed_next;
                    end
                    if (reach) begin
                        state_reg <= touch_key_pkg::HOLD_DONE;
                    end
                end
                default: begin
                    state_reg <= touch_key_pkg::HOLD_DONE;
                end
            endcase
        end
    end

    // Done state waits for release: one event per continuous hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire <= 1'b0;
        end else begin
            fire <= reach && arm;
        end
    end
endmodule

// ### touch_key_regs.sv
// Implementation choice: the APB register port.
`timescale 1ns/10ps
// Function
// - Power key select low three bits: 000 input one, 001 two, 010 three
// - Config bit six enables hold detection in Standby, reset zero
// - Config bit two enables hold detection in Active, reset zero
// - Standby: event and status flag after touch held for bits 5:4 time
// - Active: event and status flag after touch held for bits 1:0 time
// - Hold codes: 00 280 ms, 01 560 ms, 10 1.12 s reset, 11 2.24 s
// - Read-only 10-bit calibration: high bytes per input, low pairs packed
// - Calibration value at minimum or maximum code flags a failure
// - Per-input 2-bit calibration gain fields in bits 1:0, 3:2, 5:4
// - Read-only product identifier returns fixed value
// - Read-only vendor identifier returns fixed value
// - Read-only revision register returns fixed value
// - Power key status flag is bit four of general status
module touch_key_regs #(
    parameter int TICK_CYCLES = touch_key_pkg::TICK_CYCLES,
    // Identification values are arbitrary
    parameter logic [7:0] PRODUCT_IDENTIFIER = 8'h11,
    parameter logic [7:0] VENDOR_ID = 8'h22,
    parameter logic [7:0] REVISION_ID = 8'h33
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [touch_key_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] touch_active,
    input wire logic standby_state,
    input wire touch_key_pkg::cal_in_s cal_in,
    output logic power_key_event,
    output logic power_key_status_flag,
    output logic [2:0] cal_fail,
    output logic [touch_key_pkg::GAIN_W-1:0] cal_gain
);
    logic [7:0] select_reg;
    logic [7:0] config_reg;
    logic [7:0] gain_reg;
    logic [2:0][9:0] cal_reg;
    logic [2:0] fail_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic status_reg;
    logic [7:0] index;
    logic setup;
    logic wr;
    logic [7:0] rd_next;
    logic mapped;
    logic key_touched;
    logic hold_en;
    logic [1:0] hold_code;
    logic [11:0] limit_ms;
    logic [11:0] elapsed_ms;
    logic fire;
    logic clear_flag;

    assign index = paddr[touch_key_pkg::ADDR_W-1:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    // Zero wait states: read data is caught in the setup cycle
    assign pready = 1'b1;

    always_comb begin
        rd_next = 8'h00;
        mapped = 1'b1;
        if (index == touch_key_pkg::IDX_STATUS) begin
            rd_next[touch_key_pkg::STATUS_KEY_BIT] = status_reg;
        end else if (index == touch_key_pkg::IDX_SELECT) begin
            rd_next = select_reg;
        end else if (index == touch_key_pkg::IDX_CONFIG) begin
            rd_next = config_reg;
        end else if (index == touch_key_pkg::IDX_GAIN) begin
            rd_next = gain_reg;
        end else if (index == touch_key_pkg::IDX_CAL1) begin
            rd_next = cal_reg[0][9:2];
        end else if (index == touch_key_pkg::IDX_CAL2) begin
            rd_next = cal_reg[1][9:2];
        end else if (index == touch_key_pkg::IDX_CAL3) begin
            rd_next = cal_reg[2][9:2];
        end else if (index == touch_key_pkg::IDX_CAL_LOW) begin
            rd_next = {2'b00, cal_reg[2][1:0], cal_reg[1][1:0], cal_reg[0][1:0]};
        end else if (index == touch_key_pkg::IDX_PRODUCT) begin
            rd_next = PRODUCT_IDENTIFIER;
        end else if (index == touch_key_pkg::IDX_VENDOR) begin
            rd_next = VENDOR_ID;
        end else if (index == touch_key_pkg::IDX_REVISION) begin
            rd_next = REVISION_ID;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rd_next};
            pslverr <= !mapped;
        end
    end

    // Writes to read-only registers are dropped without error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= touch_key_pkg::SELECT_RST;
            config_reg <= touch_key_pkg::CONFIG_RST;
            gain_reg <= touch_key_pkg::GAIN_RST;
        end else if (wr) begin
            if (index == touch_key_pkg::IDX_SELECT) begin
                select_reg <= {5'h00, pwdata[touch_key_pkg::SEL_W-1:0]};
            end else if (index == touch_key_pkg::IDX_CONFIG) begin
                config_reg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            end else if (index == touch_key_pkg::IDX_GAIN) begin
                gain_reg <= {2'b00, pwdata[touch_key_pkg::GAIN_W-1:0]};
            end
        end
    end

    assign cal_gain = gain_reg[touch_key_pkg::GAIN_W-1:0];

    // Calibration results and failure flags, one slice per input
    genvar gi;
    generate
        for (gi = 0; gi < touch_key_pkg::NUM_INPUTS; gi++) begin : g_cal
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cal_reg[gi] <= touch_key_pkg::CAL_RST;
                    fail_reg[gi] <= 1'b0;
                end else if (cal_in.valid[gi]) begin
                    cal_reg[gi] <= cal_in.value[gi];
                    fail_reg[gi] <= (cal_in.value[gi] == touch_key_pkg::CAL_MIN) ||
                                    (cal_in.value[gi] == touch_key_pkg::CAL_MAX);
                end
            end
        end
    endgenerate

    assign cal_fail = fail_reg;

    // Millisecond tick keeps the hold counter narrow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    always_comb begin
        key_touched = 1'b0;
        if (select_reg[2:0] == 3'h0) begin
            key_touched = touch_active[0];
        end else if (select_reg[2:0] == 3'h1) begin
            key_touched = touch_active[1];
        end else if (select_reg[2:0] == 3'h2) begin
            key_touched = touch_active[2];
        end else begin
            key_touched = 1'b0;
        end
    end

    always_comb begin
        if (standby_state) begin
            hold_en = config_reg[touch_key_pkg::CFG_STBY_EN_BIT];
            hold_code = config_reg[touch_key_pkg::CFG_STBY_TIME_LSB +: 2];
        end else begin
            hold_en = config_reg[touch_key_pkg::CFG_ACT_EN_BIT];
            hold_code = config_reg[touch_key_pkg::CFG_ACT_TIME_LSB +: 2];
        end
        case (hold_code)
            2'h0: limit_ms = touch_key_pkg::HOLD_0_MS;
            2'h1: limit_ms = touch_key_pkg::HOLD_1_MS;
            2'h2: limit_ms = touch_key_pkg::HOLD_2_MS;
            default: limit_ms = touch_key_pkg::HOLD_3_MS;
        endcase
    end

    hold_timer u_hold (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick_reg),
        .arm(key_touched && hold_en),
        .limit_ms(limit_ms),
        .elapsed_ms(elapsed_ms),
        .fire(fire)
    );

    // Write one to the flag bit clears it; a new event in that cycle wins
    assign clear_flag = wr && (index == touch_key_pkg::IDX_STATUS) &&
                        pwdata[touch_key_pkg::STATUS_KEY_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 1'b0;
        end else if (fire) begin
            status_reg <= 1'b1;
        end else if (clear_flag) begin
            status_reg <= 1'b0;
        end
    end

    assign power_key_event = fire;
    assign power_key_status_flag = status_reg;

    sequence s_setup(logic [7:0] idx);
        psel && !penable && !pwrite && (index == idx);
    endsequence

    sequence s_write(logic [7:0] idx);
        psel && penable && pwrite && (index == idx);
    endsequence

    // Setup then access: data checked in the access cycle
    sequence s_read(logic [7:0] idx);
        s_setup(idx) ##1 (psel && penable);
    endsequence

    AST_EVENT_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> status_reg)
        else $error("Hold event did not set the status flag");

    AST_NO_SELECT_NO_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (select_reg[2:0] > 3'h2) [*2] |-> !fire)
        else $error("Event with no input designated");

    AST_STBY_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
        (standby_state && !config_reg[6]) [*2] |-> !fire)
        else $error("Standby event while disabled");

    AST_ACT_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
        (!standby_state && !config_reg[2]) [*2] |-> !fire)
        else $error("Active event while disabled");

    AST_HOLD_TIME: assert property (@(posedge pclk) disable iff (!presetn)
        fire && $stable(limit_ms) |-> elapsed_ms == limit_ms)
        else $error("Hold event at wrong elapsed time");

    AST_ONE_PER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> !fire [*8])
        else $error("Repeated event within one hold");

    AST_CAL_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
        cal_in.valid[0] && (cal_in.value[0] == 10'h3ff || cal_in.value[0] == 10'h000)
        |=> cal_fail[0])
        else $error("Calibration failure not flagged");

    AST_CAL_LOW_PACK: assert property (@(posedge pclk) disable iff (!presetn)
        s_read(touch_key_pkg::IDX_CAL_LOW) |->
        prdata == {26'h0, $past({cal_reg[2][1:0], cal_reg[1][1:0], cal_reg[0][1:0]})})
        else $error("Calibration low bits packed wrongly");

    AST_PRODUCT_IDENTIFIER: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup(touch_key_pkg::IDX_PRODUCT) |=> prdata == {24'h000000, PRODUCT_IDENTIFIER})
        else $error("Product identifier read wrong");

    AST_VENDOR_ID: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup(touch_key_pkg::IDX_VENDOR) |=> prdata == {24'h000000, VENDOR_ID})
        else $error("Vendor identifier read wrong");

    AST_REVISION_ID: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup(touch_key_pkg::IDX_REVISION) |=> prdata == {24'h000000, REVISION_ID})
        else $error("Revision read wrong");

    AST_GAIN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_write(touch_key_pkg::IDX_GAIN) |=> cal_gain == $past(pwdata[5:0]))
        else $error("Gain write not applied");

    AST_SELECT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_write(touch_key_pkg::IDX_SELECT) |=> select_reg == {5'h00, $past(pwdata[2:0])})
        else $error("Select write not applied");

    // Hold times as literals, so a wrong package constant is caught here
    AST_ACT_SHORTEST: assert property (@(posedge pclk) disable iff (!presetn)
        !standby_state && config_reg[1:0] == 2'h0 |-> limit_ms == 12'h118)
        else $error("Active hold code 0 decoded wrongly");

    AST_ACT_DEFAULT: assert property (@(posedge pclk) disable iff (!presetn)
        !standby_state && config_reg[1:0] == 2'h2 |-> limit_ms == 12'h460)
        else $error("Active hold code 2 decoded wrongly");

    AST_STBY_LONGEST: assert property (@(posedge pclk) disable iff (!presetn)
        standby_state && config_reg[5:4] == 2'h3 |-> limit_ms == 12'h8c0)
        else $error("Standby hold code 3 decoded wrongly");

    AST_CONFIG_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_write(touch_key_pkg::IDX_CONFIG) |=>
        config_reg[6] == $past(pwdata[6]) && config_reg[2] == $past(pwdata[2]))
        else $error("Enable bits not written");

    AST_STBY_TIME_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_write(touch_key_pkg::IDX_CONFIG) |=> config_reg[5:4] == $past(pwdata[5:4]))
        else $error("Standby hold time not written");

    AST_ACT_TIME_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        s_write(touch_key_pkg::IDX_CONFIG) |=> config_reg[1:0] == $past(pwdata[1:0]))
        else $error("Active hold time not written");

    AST_KEY_INPUT_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        select_reg[2:0] == 3'h0 |-> key_touched == touch_active[0])
        else $error("Input one not used as power key");

    AST_KEY_INPUT_THREE: assert property (@(posedge pclk) disable iff (!presetn)
        select_reg[2:0] == 3'h2 |-> key_touched == touch_active[2])
        else $error("Input three not used as power key");

    AST_STATUS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        clear_flag && !fire |=> !status_reg)
        else $error("Status flag not cleared");

    AST_STATUS_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        !fire && !clear_flag |=> status_reg == $past(status_reg))
        else $error("Status flag changed with no cause");

    AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
        s_read(touch_key_pkg::IDX_STATUS) |-> prdata == {27'h0, $past(status_reg), 4'h0})
        else $error("Status flag read wrong");

    AST_CAL_READ: assert property (@(posedge pclk) disable iff (!presetn)
        s_read(touch_key_pkg::IDX_CAL1) |-> prdata == {24'h000000, $past(cal_reg[0][9:2])})
        else $error("Calibration high byte read wrong");

    AST_CAL_RO: assert property (@(posedge pclk) disable iff (!presetn)
        s_write(touch_key_pkg::IDX_CAL1) ##0 !cal_in.valid[0] |=> $stable(cal_reg[0]))
        else $error("Calibration value changed by a write");

    AST_CAL_GOOD: assert property (@(posedge pclk) disable iff (!presetn)
        cal_in.valid[1] && cal_in.value[1] != 10'h000 && cal_in.value[1] != 10'h3ff
        |=> !cal_fail[1])
        else $error("Calibration failure flagged for a good value");

    AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
        !(key_touched && hold_en) |=> elapsed_ms == 12'h000)
        else $error("Hold timer not restarted on release");
endmodule

// ### apb_host.sv
`timescale 1ns/10ps
module apb_host (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [touch_key_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Called just after a rising edge; the request holds until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench timeout ends a stalled wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so the next call never reassigns psel in this time step
        @(posedge pclk);
    endtask
endmodule

// ### touch_key_regs_bench.sv
`timescale 1ns/10ps
module touch_key_regs_bench;
    // Short tick keeps the 2.24 s hold under nine thousand cycles
    localparam int TC = 4;
    // Identification values are arbitrary
    localparam logic [7:0] PID = 8'h4c;
    localparam logic [7:0] VID = 8'h7e;
    localparam logic [7:0] RID = 8'h19;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, standby_state, err;
    logic [touch_key_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] touch_active, cal_fail;
    logic [5:0] cal_gain;
    logic power_key_event, power_key_status_flag;
    touch_key_pkg::cal_in_s cal_in;
    logic [7:0] ri [11];
    logic [7:0] re [11];
    int bad_count, n_checks, cyc;
    int lims [4] = '{280, 560, 1120, 2240};

    touch_key_regs #(.TICK_CYCLES(TC), .PRODUCT_IDENTIFIER(PID), .VENDOR_ID(VID),
        .REVISION_ID(RID)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .touch_active(touch_active),
        .standby_state(standby_state), .cal_in(cal_in), .power_key_event(power_key_event),
        .power_key_status_flag(power_key_status_flag), .cal_fail(cal_fail),
        .cal_gain(cal_gain));

    apb_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic xerr);
        host.xfer(1'b0, idx, 32'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, xerr});
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, idx, d, rd, err);
    endtask

    // Touch held with no event expected over the whole span
    task automatic quiet(input logic [2:0] tch, input int cycles);
        int e;
        e = 0;
        touch_active <= tch;
        repeat (cycles) begin
            @(posedge pclk);
            e += int'(power_key_event === 1'b1);
        end
        touch_active <= 3'h0;
        repeat (4) @(posedge pclk);
        check(32'(e), 32'h0);
    endtask

    // Event must land within one tick of the hold time, then stay single while held
    task automatic hold(input logic [2:0] tch, input int lim, input int extra);
        int n;
        int e;
        n = 0;
        e = 0;
        touch_active <= tch;
        while (power_key_event !== 1'b1 && n < (lim + 2) * TC) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n >= (lim - 1) * TC && n <= lim * TC + 4), 32'h1);
        repeat (extra) begin
            @(posedge pclk);
            e += int'(power_key_event === 1'b1);
        end
        check(32'(e), 32'h0);
        touch_active <= 3'h0;
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        touch_active = 3'h0;
        standby_state = 1'b0;
        cal_in = '0;
        bad_count = 0;
        n_checks = 0;
        cyc = 0;
        ri = '{touch_key_pkg::IDX_SELECT, touch_key_pkg::IDX_CONFIG, touch_key_pkg::IDX_GAIN,
            touch_key_pkg::IDX_CAL1, touch_key_pkg::IDX_CAL2, touch_key_pkg::IDX_CAL3,
            touch_key_pkg::IDX_CAL_LOW, touch_key_pkg::IDX_PRODUCT, touch_key_pkg::IDX_VENDOR,
            touch_key_pkg::IDX_REVISION, touch_key_pkg::IDX_STATUS};
        re = '{8'h00, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, PID, VID, RID, 8'h00};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            rd_chk(ri[i], {24'h0, re[i]}, 1'b0);
        end
        check({29'h0, cal_fail}, 32'h0);
        wr(touch_key_pkg::IDX_CONFIG, 32'hff);
        rd_chk(touch_key_pkg::IDX_CONFIG, 32'h77, 1'b0);
        wr(touch_key_pkg::IDX_GAIN, 32'h24);
        rd_chk(touch_key_pkg::IDX_GAIN, 32'h24, 1'b0);
        check({26'h0, cal_gain}, 32'h24);
        wr(touch_key_pkg::IDX_SELECT, 32'hfa);
        rd_chk(touch_key_pkg::IDX_SELECT, 32'h02, 1'b0);
        wr(touch_key_pkg::IDX_CAL1, 32'h55);
        rd_chk(touch_key_pkg::IDX_CAL1, 32'h0, 1'b0);
        rd_chk(8'h03, 32'h0, 1'b1);
        cal_in.valid <= 3'b111;
        cal_in.value <= {10'h2a5, 10'h3ff, 10'h000};
        @(posedge pclk);
        cal_in.valid <= 3'b000;
        @(posedge pclk);
        check({29'h0, cal_fail}, 32'h3);
        rd_chk(touch_key_pkg::IDX_CAL2, 32'hff, 1'b0);
        rd_chk(touch_key_pkg::IDX_CAL3, 32'ha9, 1'b0);
        rd_chk(touch_key_pkg::IDX_CAL_LOW, 32'h1c, 1'b0);
        cal_in.valid <= 3'b001;
        cal_in.value[0] <= 10'h3fe;
        @(posedge pclk);
        cal_in.valid <= 3'b000;
        @(posedge pclk);
        check({29'h0, cal_fail}, 32'h2);
        wr(touch_key_pkg::IDX_CONFIG, 32'h04);
        for (int s = 0; s < 3; s++) begin
            wr(touch_key_pkg::IDX_SELECT, 32'(s));
            quiet(~(3'h1 << s), 300 * TC);
            hold(3'h1 << s, 280, 300 * TC);
        end
        check({31'h0, power_key_status_flag}, 32'h1);
        rd_chk(touch_key_pkg::IDX_STATUS, 32'h10, 1'b0);
        wr(touch_key_pkg::IDX_STATUS, 32'h10);
        check({31'h0, power_key_status_flag}, 32'h0);
        wr(touch_key_pkg::IDX_CONFIG, 32'h05);
        touch_active <= 3'h4;
        repeat (500 * TC) @(posedge pclk);
        touch_active <= 3'h0;
        repeat (2) @(posedge pclk);
        hold(3'h4, 560, 0);
        wr(touch_key_pkg::IDX_CONFIG, 32'h04);
        for (int s = 3; s < 8; s++) begin
            wr(touch_key_pkg::IDX_SELECT, 32'(s));
            quiet(3'h7, 290 * TC);
        end
        wr(touch_key_pkg::IDX_SELECT, 32'h0);
        wr(touch_key_pkg::IDX_CONFIG, 32'h00);
        quiet(3'h7, 300 * TC);
        standby_state <= 1'b1;
        wr(touch_key_pkg::IDX_CONFIG, 32'h04);
        quiet(3'h1, 300 * TC);
        for (int c = 0; c < 4; c++) begin
            wr(touch_key_pkg::IDX_CONFIG, 32'h40 | (32'(c) << 4));
            hold(3'h1, lims[c], 0);
        end
        check({31'h0, power_key_status_flag}, 32'h1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(touch_key_pkg::IDX_CONFIG, 32'h22, 1'b0);
        rd_chk(touch_key_pkg::IDX_STATUS, 32'h00, 1'b0);
        end_sim();
    end
endmodule
